// File: pclp_pkg.sv
// constants, types and helpers shared by both ends of the parallel configuration load port
// assumes one 25 MHz system clock (mclk) at each end
`default_nettype none
package pclp_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int DATA_W = 16;
    localparam int NARROW_W = 8;
    localparam int CNT_W = 20;

    // device side timing
    localparam int T_STATUS_MIN_US = 268;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int STATUS_MIN_CYC = (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MAX_CYC = (T_STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int T_CD2UM_MIN_US = 175;
    localparam int T_CD2UM_MAX_US = 437;
    localparam int CD2UM_MIN_CYC = (T_CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CD2UM_MAX_CYC = (T_CD2UM_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int CU_EDGES = 4;
    localparam int USER_INIT_CYC = 8576;

    // host side timing
    localparam int T_CFG_LOW_US = 2;
    localparam int CFG_LOW_CYC = (T_CFG_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_ST2CK_US = 2;
    localparam int ST2CK_CYC = (T_ST2CK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CF2CK_US = 1506;
    localparam int CF2CK_CYC = (T_CF2CK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_MARGIN = 8;

    // clock-to-data ratio codes
    localparam logic [2:0] RATIO_1 = 3'h1;
    localparam logic [2:0] RATIO_2 = 3'h2;
    localparam logic [2:0] RATIO_4 = 3'h4;

    function automatic logic [2:0] pclp_ratio(input logic wide16, input logic decomp, input logic secure);
        if (decomp)
        begin
            return wide16 ? RATIO_4 : RATIO_2;
        end
        else if (wide16 && secure)
        begin
            return RATIO_2;
        end
        return RATIO_1;
    endfunction

endpackage
`default_nettype wire

// File: pclp_link_if.sv
// link wires between configuration host and configured device
// assumes the status line has a pull-up: it is low while either end enables its driver
`timescale 1ns/1ps
`default_nettype none
interface pclp_link_if;
    logic cfg_request_low;
    logic st_dev_o;
    logic st_dev_oe;
    logic st_host_o;
    logic st_host_oe;
    logic cfg_state_low;
    logic load_complete;
    logic cfg_clock;
    logic user_init_clock;
    logic [15:0] cfg_data;

    assign cfg_state_low = (st_dev_oe ? st_dev_o : 1'b1) & (st_host_oe ? st_host_o : 1'b1);

    modport dev (
        input cfg_request_low,
        output st_dev_o,
        output st_dev_oe,
        input cfg_state_low,
        output load_complete,
        input cfg_clock,
        input user_init_clock,
        input cfg_data
    );

    modport host (
        output cfg_request_low,
        output st_host_o,
        output st_host_oe,
        input cfg_state_low,
        input load_complete,
        output cfg_clock,
        output user_init_clock,
        output cfg_data
    );
endinterface
`default_nettype wire

// File: pclp_device.sv
// device end of the parallel configuration load port: takes words, reports status, enters user mode
// assumes link pins are asynchronous to mclk and the host keeps its side of the protocol
`timescale 1ns/1ps
`default_nettype none
module pclp_device #(
    parameter int WORD_CNT_W = 24,
    parameter int STATUS_LOW_CYC = pclp_pkg::STATUS_MIN_CYC,
    parameter int OSC_INIT_CYC = pclp_pkg::CD2UM_MIN_CYC
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    pclp_link_if.dev link, // link to the host
    input wire logic wide16, // 16-bit load mode when high
    input wire logic decomp_on, // decompression enabled
    input wire logic secure_on, // design security enabled
    input wire logic user_clk_sel, // initialise from the user clock
    input wire logic [WORD_CNT_W-1:0] load_words, // words in one load
    output logic [pclp_pkg::DATA_W-1:0] word_data, // captured word
    output logic word_valid, // pulse with each captured word
    output logic user_mode // device in user mode
);
    import pclp_pkg::*;

    if (STATUS_LOW_CYC < STATUS_MIN_CYC || STATUS_LOW_CYC > STATUS_MAX_CYC - 8)
    begin : g_chk_status
        $error("STATUS_LOW_CYC outside the allowed status low window");
    end
    if (OSC_INIT_CYC < 1 || OSC_INIT_CYC >= (1 << CNT_W))
    begin : g_chk_osc
        $error("OSC_INIT_CYC not served by the counter");
    end
    if (WORD_CNT_W < 1 || WORD_CNT_W > 32)
    begin : g_chk_words
        $error("WORD_CNT_W out of range");
    end

    localparam logic [CNT_W-1:0] STATUS_END = CNT_W'(STATUS_LOW_CYC);
    localparam logic [CNT_W-1:0] OSC_END = CNT_W'(OSC_INIT_CYC);
    localparam logic [CNT_W-1:0] CU_END = CNT_W'(CU_EDGES);
    localparam logic [CNT_W-1:0] UINIT_END = CNT_W'(USER_INIT_CYC);

    typedef enum logic [2:0] {
        PD_RST = 3'b000,
        PD_REL = 3'b001,
        PD_LOAD = 3'b010,
        PD_CUWAIT = 3'b011,
        PD_OINIT = 3'b100,
        PD_UINIT = 3'b101,
        PD_USER = 3'b110
    } pclp_dst_t;

    typedef struct packed {
        pclp_dst_t st;
        logic req_s1;
        logic req_s2;
        logic sl_s1;
        logic sl_s2;
        logic ck_s1;
        logic ck_s2;
        logic ck_prev;
        logic uc_s1;
        logic uc_s2;
        logic uc_prev;
        logic [DATA_W-1:0] d_s1;
        logic [DATA_W-1:0] d_s2;
        logic [CNT_W-1:0] cnt;
        logic [2:0] phase;
        logic [WORD_CNT_W-1:0] words;
        logic st_oe;
        logic done;
        logic [DATA_W-1:0] word;
        logic wvalid;
        logic umode;
    } pclp_dev_state_t;

    pclp_dev_state_t r;
    pclp_dev_state_t next_r;

    logic ck_rise;
    logic uc_rise;
    logic [2:0] ratio;
    logic last_phase;
    logic [WORD_CNT_W-1:0] words_after;

    always_comb
    begin
        ck_rise = r.ck_s2 & ~r.ck_prev;
        uc_rise = r.uc_s2 & ~r.uc_prev;
        ratio = pclp_ratio(wide16, decomp_on, secure_on);
        last_phase = (r.phase == ratio - 3'h1);
        words_after = (r.phase == 3'h0) ? r.words + WORD_CNT_W'(1) : r.words;
        next_r = r;
        next_r.req_s1 = link.cfg_request_low;
        next_r.req_s2 = r.req_s1;
        next_r.sl_s1 = link.cfg_state_low;
        next_r.sl_s2 = r.sl_s1;
        next_r.ck_s1 = link.cfg_clock;
        next_r.ck_s2 = r.ck_s1;
        next_r.ck_prev = r.ck_s2;
        next_r.uc_s1 = link.user_init_clock;
        next_r.uc_s2 = r.uc_s1;
        next_r.uc_prev = r.uc_s2;
        next_r.d_s1 = link.cfg_data;
        next_r.d_s2 = r.d_s1;
        next_r.wvalid = 1'b0;
        if (!r.req_s2 && r.st != PD_RST)
        begin
            // a falling request restarts the load from any state but PD_RST
            next_r.st = PD_RST;
            next_r.cnt = '0;
            next_r.st_oe = 1'b1;
            next_r.done = 1'b0;
            next_r.umode = 1'b0;
        end
        else
        begin
            unique case (r.st)
                PD_RST:
                begin
                    next_r.st_oe = 1'b1;
                    next_r.done = 1'b0;
                    next_r.umode = 1'b0;
                    if (r.cnt < STATUS_END)
                    begin
                        next_r.cnt = r.cnt + CNT_W'(1);
                    end
                    else if (r.req_s2)
                    begin
                        // longer request low only stretches the status pulse
                        next_r.st_oe = 1'b0;
                        next_r.st = PD_REL;
                        next_r.cnt = '0;
                    end
                end
                PD_REL:
                begin
                    if (r.sl_s2)
                    begin
                        next_r.st = PD_LOAD;
                        next_r.phase = 3'h0;
                        next_r.words = '0;
                    end
                end
                PD_LOAD:
                begin
                    if (ck_rise)
                    begin
                        if (r.phase == 3'h0)
                        begin
                            next_r.word = wide16 ? r.d_s2 : {{(DATA_W - NARROW_W){1'b0}}, r.d_s2[NARROW_W-1:0]};
                            next_r.wvalid = 1'b1;
                            next_r.words = words_after;
                        end
                        next_r.phase = last_phase ? 3'h0 : r.phase + 3'h1;
                        if (last_phase && words_after == load_words)
                        begin
                            next_r.done = 1'b1;
                            next_r.cnt = '0;
                            next_r.st = user_clk_sel ? PD_CUWAIT : PD_OINIT;
                        end
                    end
                end
                PD_CUWAIT:
                begin
                    if (ck_rise)
                    begin
                        next_r.cnt = r.cnt + CNT_W'(1);
                        if (r.cnt + CNT_W'(1) == CU_END)
                        begin
                            next_r.cnt = '0;
                            next_r.st = PD_UINIT;
                        end
                    end
                end
                PD_OINIT:
                begin
                    next_r.cnt = r.cnt + CNT_W'(1);
                    if (r.cnt + CNT_W'(1) == OSC_END)
                    begin
                        next_r.umode = 1'b1;
                        next_r.st = PD_USER;
                    end
                end
                PD_UINIT:
                begin
                    if (uc_rise)
                    begin
                        next_r.cnt = r.cnt + CNT_W'(1);
                        if (r.cnt + CNT_W'(1) == UINIT_END)
                        begin
                            next_r.umode = 1'b1;
                            next_r.st = PD_USER;
                        end
                    end
                end
                PD_USER:
                begin
                    next_r.umode = 1'b1;
                end
                default:
                begin
                    next_r.st = PD_RST;
                    next_r.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.st <= PD_RST;
            r.st_oe <= 1'b1;
            r.req_s1 <= 1'b1;
            r.req_s2 <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign link.st_dev_o = 1'b0;
    assign link.st_dev_oe = r.st_oe;
    assign link.load_complete = r.done;
    assign word_data = r.word;
    assign word_valid = r.wvalid;
    assign user_mode = r.umode;
endmodule
`default_nettype wire

// File: pclp_host.sv
// host end of the parallel configuration load port: requests a load and clocks words out
// assumes the word source holds word_in and word_in_valid until word_take pulses
`timescale 1ns/1ps
`default_nettype none
module pclp_host #(
    parameter int HALF_CYC = 4,
    parameter int CF2CK_WAIT = pclp_pkg::CF2CK_CYC,
    parameter int INIT_EDGES = pclp_pkg::CU_EDGES + pclp_pkg::USER_INIT_CYC + pclp_pkg::INIT_MARGIN
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    pclp_link_if.host link, // link to the device
    input wire logic start, // pulse: begin a load
    input wire logic wide16, // 16-bit load mode when high
    input wire logic decomp_on, // decompression enabled
    input wire logic secure_on, // design security enabled
    input wire logic user_clk_sel, // supply the user init clock
    input wire logic watch_status, // wait on the status line
    input wire logic hold_status, // hold status line low to delay
    input wire logic [pclp_pkg::DATA_W-1:0] word_in, // next word to send
    input wire logic word_in_last, // word_in is the final word
    input wire logic word_in_valid, // word_in present
    output logic word_take, // pulse: word_in consumed
    output logic busy, // load in progress
    output logic done // pulse: load finished, plus user clock init when user_clk_sel
);
    import pclp_pkg::*;

    if (HALF_CYC < 1 || HALF_CYC > 255)
    begin : g_chk_half
        $error("HALF_CYC out of range");
    end
    if (CF2CK_WAIT < CF2CK_CYC || CF2CK_WAIT >= (1 << CNT_W) || INIT_EDGES >= (1 << CNT_W))
    begin : g_chk_wait
        $error("wait counts not served by the counter");
    end

    localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] REQ_END = CNT_W'(CFG_LOW_CYC);
    localparam logic [CNT_W-1:0] ST2CK_END = CNT_W'(ST2CK_CYC);
    localparam logic [CNT_W-1:0] CF2CK_END = CNT_W'(CF2CK_WAIT);
    localparam logic [CNT_W-1:0] INIT_END = CNT_W'(INIT_EDGES);

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_REQ = 3'b001,
        PH_WREL = 3'b010,
        PH_FETCH = 3'b011,
        PH_CLK = 3'b100,
        PH_DONEW = 3'b101,
        PH_INIT = 3'b110
    } pclp_hst_t;

    typedef struct packed {
        pclp_hst_t st;
        logic sl_s1;
        logic sl_s2;
        logic ld_s1;
        logic ld_s2;
        logic [CNT_W-1:0] cnt;
        logic [7:0] hc;
        logic [2:0] pc;
        logic ck;
        logic uck;
        logic req_n;
        logic st_oe;
        logic last;
        logic [DATA_W-1:0] data;
        logic take;
        logic busy;
        logic done;
    } pclp_hst_state_t;

    pclp_hst_state_t r;
    pclp_hst_state_t next_r;

    logic tick;
    logic rise;
    logic fall;
    logic [2:0] ratio;
    logic [CNT_W-1:0] wait_end;

    always_comb
    begin
        ratio = pclp_ratio(wide16, decomp_on, secure_on);
        tick = (r.hc == HALF_END);
        rise = tick & ~r.ck;
        fall = tick & r.ck;
        wait_end = watch_status ? ST2CK_END : CF2CK_END;
        next_r = r;
        next_r.sl_s1 = link.cfg_state_low;
        next_r.sl_s2 = r.sl_s1;
        next_r.ld_s1 = link.load_complete;
        next_r.ld_s2 = r.ld_s1;
        next_r.st_oe = hold_status;
        next_r.take = 1'b0;
        next_r.done = 1'b0;
        if (r.st == PH_CLK || r.st == PH_DONEW || r.st == PH_INIT)
        begin
            next_r.hc = tick ? 8'h00 : r.hc + 8'h01;
            if (tick)
            begin
                next_r.ck = ~r.ck;
                next_r.uck = ~r.ck & user_clk_sel & (r.st != PH_CLK);
            end
        end
        unique case (r.st)
            PH_IDLE:
            begin
                next_r.busy = 1'b0;
                if (start)
                begin
                    next_r.st = PH_REQ;
                    next_r.req_n = 1'b0;
                    next_r.busy = 1'b1;
                    next_r.cnt = '0;
                end
            end
            PH_REQ:
            begin
                next_r.cnt = r.cnt + CNT_W'(1);
                if (r.cnt + CNT_W'(1) == REQ_END)
                begin
                    next_r.req_n = 1'b1;
                    next_r.cnt = '0;
                    next_r.st = PH_WREL;
                end
            end
            PH_WREL:
            begin
                if (watch_status && !r.sl_s2)
                begin
                    next_r.cnt = '0;
                end
                else if (r.cnt + CNT_W'(1) == wait_end)
                begin
                    next_r.st = PH_FETCH;
                end
                else
                begin
                    next_r.cnt = r.cnt + CNT_W'(1);
                end
            end
            PH_FETCH:
            begin
                if (word_in_valid)
                begin
                    next_r.data = word_in;
                    next_r.last = word_in_last;
                    next_r.take = 1'b1;
                    next_r.pc = 3'h0;
                    next_r.hc = 8'h00;
                    next_r.st = PH_CLK;
                end
            end
            PH_CLK:
            begin
                if (rise)
                begin
                    next_r.pc = r.pc + 3'h1;
                end
                if (fall && r.pc == ratio)
                begin
                    // data moves only once the word has had all its clocks
                    next_r.cnt = '0;
                    next_r.st = r.last ? PH_DONEW : PH_FETCH;
                end
            end
            PH_DONEW:
            begin
                if (r.ld_s2)
                begin
                    next_r.st = PH_INIT;
                    next_r.cnt = '0;
                end
            end
            PH_INIT:
            begin
                if (rise)
                begin
                    next_r.cnt = r.cnt + CNT_W'(1);
                end
                if (!user_clk_sel || (rise && r.cnt + CNT_W'(1) == INIT_END))
                begin
                    next_r.st = PH_IDLE;
                    next_r.ck = 1'b0;
                    next_r.uck = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end
            end
            default:
            begin
                next_r.st = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.st <= PH_IDLE;
            r.req_n <= 1'b1;
            r.sl_s1 <= 1'b1;
            r.sl_s2 <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign link.cfg_request_low = r.req_n;
    assign link.st_host_o = 1'b0;
    assign link.st_host_oe = r.st_oe;
    assign link.cfg_clock = r.ck;
    assign link.user_init_clock = r.uck;
    assign link.cfg_data = r.data;
    assign word_take = r.take;
    assign busy = r.busy;
    assign done = r.done;
endmodule
`default_nettype wire

// File: pclp_link_properties.sv
// checker for the link between the host and device ends of the configuration load port
// assumes the signals of one pclp_link_if and the shared 25 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module pclp_link_checker (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic cfg_request_low, // load request, low active
    input wire logic st_dev_oe, // device status driver enable
    input wire logic cfg_state_low, // resolved status line
    input wire logic load_complete, // all words taken
    input wire logic cfg_clock, // configuration clock
    input wire logic user_init_clock, // user initialisation clock
    input wire logic [15:0] cfg_data // word on the link
);
    import pclp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    int unsigned n_oe;
    int unsigned n_oe_hi;
    int unsigned n_req;
    int unsigned n_st;

    // run lengths of driver enable, request low and status high
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            n_oe <= 0;
            n_oe_hi <= 0;
            n_req <= 0;
            n_st <= 0;
        end
        else
        begin
            n_oe <= st_dev_oe ? n_oe + 1 : 0;
            n_oe_hi <= (st_dev_oe && cfg_request_low) ? n_oe_hi + 1 : 0;
            n_req <= cfg_request_low ? 0 : n_req + 1;
            n_st <= cfg_state_low ? n_st + 1 : 0;
        end
    end

    property p_st_fall;
        $fell(cfg_request_low) |-> ##[1:15] !cfg_state_low;
    endproperty
    a_st_fall: assert property (p_st_fall) else $error("status not low after request");
    property p_lc_fall;
        $fell(cfg_request_low) |-> ##[1:15] !load_complete;
    endproperty
    a_lc_fall: assert property (p_lc_fall) else $error("load complete not low after request");
    property p_st_min;
        $fell(st_dev_oe) |-> n_oe >= STATUS_MIN_CYC;
    endproperty
    a_st_min: assert property (p_st_min) else $error("status low pulse too short");
    property p_st_max;
        st_dev_oe |-> n_oe_hi <= STATUS_MAX_CYC;
    endproperty
    a_st_max: assert property (p_st_max) else $error("status held too long after request");
    property p_req_hold;
        !cfg_request_low [*6] |-> !cfg_state_low;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("status released during request");
    property p_req_min;
        $rose(cfg_request_low) |-> n_req >= CFG_LOW_CYC;
    endproperty
    a_req_min: assert property (p_req_min) else $error("request pulse too short");
    property p_ck_wait;
        $rose(cfg_clock) |-> n_st >= ST2CK_CYC;
    endproperty
    a_ck_wait: assert property (p_ck_wait) else $error("clock edge too soon after status");
    property p_data_hold;
        cfg_clock |-> $stable(cfg_data);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_uclk_idle;
        !load_complete |-> $stable(user_init_clock);
    endproperty
    a_uclk_idle: assert property (p_uclk_idle) else $error("user clock before load complete");

    c_load_done: cover property ($rose(load_complete));
    c_status_end: cover property ($fell(st_dev_oe));
    c_held_low: cover property (!cfg_state_low && !st_dev_oe);
    c_user_init: cover property ($rose(user_init_clock));
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench: host and device ends joined by the link, one load per mode combination
// assumes pclp_pkg, the link interface and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pclp_pkg::*;
    localparam int OSC_CYC = 20;
    // short link clock period keeps the user-clock initialisation inside the run budget
    localparam int HALF = 2;
    localparam int UC_EXP = (CU_EDGES + USER_INIT_CYC) * 2 * HALF;
    localparam logic [2:0] EXP_RATIO [8] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h2, 3'h4, 3'h4};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic wide16 = 1'b0;
    logic decomp_on = 1'b0;
    logic secure_on = 1'b0;
    logic hold_status = 1'b0;
    logic user_clk_sel = 1'b0;
    bit timed_out = 1'b0;
    logic [DATA_W-1:0] word_in = '0;
    logic word_in_last = 1'b0;
    logic word_in_valid = 1'b0;
    logic word_take, busy, done, word_valid, user_mode;
    logic [DATA_W-1:0] word_data;
    int num_errors = 0;
    int samples_checked = 0;
    pclp_link_if link();
    always #20 mclk = ~mclk;

    pclp_device #(.OSC_INIT_CYC(OSC_CYC)) u_pclp_device (.mclk(mclk), .sys_rst(sys_rst), .link(link),
        .wide16(wide16), .decomp_on(decomp_on), .secure_on(secure_on), .user_clk_sel(user_clk_sel),
        .load_words(24'h00_0003), .word_data(word_data), .word_valid(word_valid), .user_mode(user_mode));
    pclp_host #(.HALF_CYC(HALF)) u_pclp_host (.mclk(mclk), .sys_rst(sys_rst), .link(link), .start(start),
        .wide16(wide16), .decomp_on(decomp_on), .secure_on(secure_on), .user_clk_sel(user_clk_sel),
        .watch_status(1'b1), .hold_status(hold_status), .word_in(word_in), .word_in_last(word_in_last),
        .word_in_valid(word_in_valid), .word_take(word_take), .busy(busy), .done(done));
    pclp_link_checker u_pclp_link_checker (.mclk(mclk), .sys_rst(sys_rst),
        .cfg_request_low(link.cfg_request_low), .st_dev_oe(link.st_dev_oe), .cfg_state_low(link.cfg_state_low),
        .load_complete(link.load_complete), .cfg_clock(link.cfg_clock),
        .user_init_clock(link.user_init_clock), .cfg_data(link.cfg_data));

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one load of three words; hold keeps the status line low from our side for a while
    task automatic run_load(input logic w, input logic d, input logic s, input logic hold, input logic u);
        logic [DATA_W-1:0] src [3];
        logic ck_prev, lc_prev, seen_done;
        int k, got, rises, lc_at, um_at, c;
        src = '{16'hA5C3, 16'h0F96, 16'h7E18};
        @(negedge mclk);
        wide16 = w;
        decomp_on = d;
        secure_on = s;
        hold_status = hold;
        user_clk_sel = u;
        k = 0;
        got = 0;
        rises = 0;
        lc_at = -1;
        um_at = -1;
        seen_done = 1'b0;
        word_in = src[0];
        word_in_last = 1'b0;
        word_in_valid = 1'b1;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        check(busy === 1'b1, "host busy after start");
        ck_prev = link.cfg_clock;
        lc_prev = link.load_complete;
        for (c = 0; c < 50000 && !(um_at >= 0 && seen_done); c++)
        begin
            @(negedge mclk);
            if (hold && c == 7500)
            begin
                check(link.cfg_state_low === 1'b0 && got == 0 && rises == 0, "load went on while held");
                hold_status = 1'b0;
            end
            if (link.cfg_clock === 1'b1 && ck_prev === 1'b0)
                rises++;
            ck_prev = link.cfg_clock;
            if (word_take === 1'b1)
            begin
                k++;
                word_in = src[k % 3];
                word_in_last = (k == 2);
                word_in_valid = (k < 3);
            end
            if (word_valid === 1'b1)
            begin
                check(word_data === (w ? src[got % 3] : {8'h00, src[got % 3][7:0]}), "captured word");
                if (got > 0)
                    check(rises == EXP_RATIO[{w, d, s}], "clock edges per word");
                rises = 0;
                got++;
            end
            if (link.load_complete === 1'b1 && lc_prev === 1'b0)
                lc_at = c;
            lc_prev = link.load_complete;
            if (user_mode === 1'b1 && um_at < 0 && lc_at >= 0)
                um_at = c;
            if (done === 1'b1)
                seen_done = 1'b1;
        end
        if (c >= 50000)
        begin
            check(1'b0, "load timed out");
            timed_out = 1'b1;
            return;
        end
        check(got == 3, "word count");
        check(busy === 1'b0, "host idle after load");
        if (u)
            check(um_at - lc_at >= UC_EXP - 1 && um_at - lc_at <= UC_EXP + 2 * HALF, "user clock init");
        else
            check(um_at - lc_at >= OSC_CYC - 1 && um_at - lc_at <= OSC_CYC + 1, "user mode delay");
        $display("load wide %0b decomp %0b secure %0b hold %0b user %0b finished", w, d, s, hold, u);
    endtask

    initial
    begin
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        for (int m = 0; m < 8 && !timed_out; m++)
        begin
            run_load(m[2], m[1], m[0], m == 5, m == 7);
        end
        final_report();
    end
endmodule
`default_nettype wire
